// >>> irp_regs.sv
// control and status register bank: ir generator, port functions, flags, counters
//
// Function
// - infrared enable off stops generator; ir pin then follows port-5 direction bit 7.
// - carrier mode off: plain high/low pulse output, counter 2 runs independently.
// - carrier mode on: low sections of the pulse carry the counter 2 carrier.
// - low-pulse-only mode ignores the high-pulse timer; low timer sets the waveform.
// - ir pin select makes pin 7 the ir output; software clears direction bit 7.
// - timer input select routes pin 6 to the timer; software sets direction bit 6.
// - ext irq 1 select uses pin 5 as interrupt input; software sets direction bit 5.
// - ext irq 0 select uses pin 4 as interrupt input; software sets direction bit 4.
// - each status bit is set by hardware when its interrupt source fires.
// - port-change flag sets when any port 6 or port 8 input changes.
// - pulse timer and counter flags set when their down-counter underflows.
// - timer-counter flag sets whenever the timer-counter overflows.
// - port-5 direction bits 7..4: 0 drives the pin, 1 makes it input.
// - bits 3 and 2 swap port 8 nibbles for lcd segments 28..31 and 24..27.
// - bits 1 and 0 swap port 7 nibbles for lcd segments 20..23 and 16..19.
// - port 6, 7, 8 direction bits: 0 drives the pin, 1 makes it input.
// - aux ram index is 7 bits; bit 7 always reads zero.
// - aux ram data register reads or writes the byte at the index.
// - counter 1 preset is readable, writable and reloaded after each underflow.
// - counter 2 preset is readable, writable and reloaded after each underflow.
// - carrier toggles on each counter 2 underflow, giving clock/(2*(preset+1)*scale).
// - pulse lengths are scale times (preset plus one) timer clocks.
// - each counter and pulse timer counts only while its enable bit is set.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module irp_regs (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [3:0]  p5In,
  input  wire logic [3:0]  p5OutData,
  output logic      [3:0]  p5Out,
  output logic      [3:0]  p5Oe,
  input  wire logic [7:0]  p6In,
  input  wire logic [7:0]  p6OutData,
  output logic      [7:0]  p6Out,
  output logic      [7:0]  p6Oe,
  input  wire logic [7:0]  p7In,
  input  wire logic [7:0]  p7OutData,
  output logic      [7:0]  p7Out,
  output logic      [7:0]  p7Oe,
  input  wire logic [7:0]  p8In,
  input  wire logic [7:0]  p8OutData,
  output logic      [7:0]  p8Out,
  output logic      [7:0]  p8Oe,
  input  wire logic [15:0] lcdSeg,
  input  wire logic        tcOverflow,
  output logic             timerExtIn,
  output logic      [7:0] irqFlags
);
  import irp_pkg::*;

  logic [7:0] p5dir_reg;
  logic [7:0] p6dir_reg;
  logic [7:0] p7dir_reg;
  logic [7:0] p8dir_reg;
  logic [7:0] ramIx_reg;
  logic [7:0] c1pre_reg;
  logic [7:0] c2pre_reg;
  logic [7:0] irctl_reg;
  logic [7:0] cnten_reg;
  logic [7:0] cscal_reg;
  logic [7:0] pscal_reg;
  logic [7:0] hppre_reg;
  logic [7:0] lppre_reg;
  logic [7:0] flags_next;
  logic [7:0] rdMux;
  logic [7:0] ramRd;
  logic [7:0] wIdx_reg;
  logic       wPend_reg;
  logic [7:0] aIdx;
  logic       aMapped;
  logic       take;
  logic       wrEv;
  logic [7:0] wb;
  logic [7:0] p5Prev_reg;
  logic [7:0] p6Prev_reg;
  logic [7:0] p8Prev_reg;
  logic       carrier_reg;
  irp_phase_e phase_reg;
  logic       c1Uf;
  logic       c2Uf;
  logic       hpUf;
  logic       lpUf;
  logic       irOn;
  logic       lowOnly;
  logic       hpRun;
  logic       lpRun;
  logic       irWave;
  logic       portChange;
  logic       irq0Edge;
  logic       irq1Edge;
  logic [7:0] setVec;
  logic [7:0] clrVec;

  // ---------------- bus slave ----------------
  assign take    = hsel & htrans[1] & hready;
  assign aIdx    = haddr[9:2];
  assign aMapped = (haddr[31:10] == 22'h0);
  assign wrEv    = wPend_reg;
  assign wb      = hwdata[7:0];

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wPend_reg <= 1'b0;
      wIdx_reg  <= 8'h00;
    end else if (hready) begin
      // unmapped writes are dropped here: no write event is raised
      wPend_reg <= take & hwrite & aMapped;
      wIdx_reg  <= aIdx;
    end
  end

  always_comb begin
    if (!aMapped) begin
      rdMux = 8'h00;
    end else if (aIdx == IDX_P5DIR) begin
      rdMux = p5dir_reg;
    end else if (aIdx == IDX_P6DIR) begin
      rdMux = p6dir_reg;
    end else if (aIdx == IDX_P7DIR) begin
      rdMux = p7dir_reg;
    end else if (aIdx == IDX_P8DIR) begin
      rdMux = p8dir_reg;
    end else if (aIdx == IDX_RAMIX) begin
      rdMux = ramIx_reg & RAM_INDEX_MASK;
    end else if (aIdx == IDX_RAMDT) begin
      rdMux = ramRd;
    end else if (aIdx == IDX_C1PRE) begin
      rdMux = c1pre_reg;
    end else if (aIdx == IDX_C2PRE) begin
      rdMux = c2pre_reg;
    end else if (aIdx == IDX_IRCTL) begin
      rdMux = irctl_reg;
    end else if (aIdx == IDX_FLAGS) begin
      rdMux = irqFlags;
    end else if (aIdx == IDX_CNTEN) begin
      rdMux = cnten_reg;
    end else if (aIdx == IDX_CSCAL) begin
      rdMux = cscal_reg;
    end else if (aIdx == IDX_PSCAL) begin
      rdMux = pscal_reg;
    end else if (aIdx == IDX_HPPRE) begin
      rdMux = hppre_reg;
    end else if (aIdx == IDX_LPPRE) begin
      rdMux = lppre_reg;
    end else begin
      rdMux = 8'h00;
    end
  end

  // read data is sampled in the address phase; zero wait states
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (take && !hwrite) begin
        hrdata <= {24'h0, rdMux};
      end
    end
  end

  // ---------------- control registers ----------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      p5dir_reg <= RST_DIR;
      p6dir_reg <= RST_DIR;
      p7dir_reg <= RST_DIR;
      p8dir_reg <= RST_DIR;
    end else if (wrEv) begin
      if (wIdx_reg == IDX_P5DIR) begin
        p5dir_reg <= wb;
      end else if (wIdx_reg == IDX_P6DIR) begin
        p6dir_reg <= wb;
      end else if (wIdx_reg == IDX_P7DIR) begin
        p7dir_reg <= wb;
      end else if (wIdx_reg == IDX_P8DIR) begin
        p8dir_reg <= wb;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irctl_reg <= RST_CTL;
      ramIx_reg <= RST_CTL;
      cnten_reg <= RST_CTL;
      cscal_reg <= RST_CTL;
      pscal_reg <= RST_CTL;
    end else if (wrEv) begin
      if (wIdx_reg == IDX_IRCTL) begin
        irctl_reg <= wb & IRC_WR_MASK;
      end else if (wIdx_reg == IDX_RAMIX) begin
        ramIx_reg <= wb & RAM_INDEX_MASK;
      end else if (wIdx_reg == IDX_CNTEN) begin
        cnten_reg <= wb;
      end else if (wIdx_reg == IDX_CSCAL) begin
        cscal_reg <= wb;
      end else if (wIdx_reg == IDX_PSCAL) begin
        pscal_reg <= wb;
      end
    end
  end

  // presets only feed the reload, so running counts are untouched
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      c1pre_reg <= RST_CTL;
      c2pre_reg <= RST_CTL;
      hppre_reg <= RST_CTL;
      lppre_reg <= RST_CTL;
    end else if (wrEv) begin
      if (wIdx_reg == IDX_C1PRE) begin
        c1pre_reg <= wb;
      end else if (wIdx_reg == IDX_C2PRE) begin
        c2pre_reg <= wb;
      end else if (wIdx_reg == IDX_HPPRE) begin
        hppre_reg <= wb;
      end else if (wIdx_reg == IDX_LPPRE) begin
        lppre_reg <= wb;
      end
    end
  end

  irp_aux_ram #(
    .AW (7),
    .DW (8)
  ) u_ram (
    .clock  (clock),
    .wrEn   (wrEv && (wIdx_reg == IDX_RAMDT)),
    .index  (ramIx_reg[6:0]),
    .wrData (wb),
    .rdData (ramRd)
  );

  // ---------------- counters and pulse timers ----------------
  assign irOn    = irctl_reg[IRC_INFRARED_ENABLE];
  assign lowOnly = irctl_reg[IRC_LOW_PULSE_ONLY];
  assign hpRun   = cnten_reg[CEN_HIGH_PULSE] & irOn & (phase_reg == IRP_HIGH) & ~lowOnly;
  assign lpRun   = cnten_reg[CEN_LOW_PULSE] & irOn & ((phase_reg == IRP_LOW) | lowOnly);

  irp_down_counter #(.W(8), .PW(8)) u_c1 (
    .clock     (clock),
    .rst_b     (rst_b),
    .enable    (cnten_reg[CEN_COUNTER_ONE]),
    .scaleSel  (cscal_reg[CSC_ONE_LSB +: 3]),
    .preset    (c1pre_reg),
    .underflow (c1Uf)
  );

  // counter 2 always runs on its enable; carrier use is layered on top
  irp_down_counter #(.W(8), .PW(8)) u_c2 (
    .clock     (clock),
    .rst_b     (rst_b),
    .enable    (cnten_reg[CEN_COUNTER_TWO]),
    .scaleSel  (cscal_reg[CSC_TWO_LSB +: 3]),
    .preset    (c2pre_reg),
    .underflow (c2Uf)
  );

  irp_down_counter #(.W(8), .PW(8)) u_hp (
    .clock     (clock),
    .rst_b     (rst_b),
    .enable    (hpRun),
    .scaleSel  (pscal_reg[2:0]),
    .preset    (hppre_reg),
    .underflow (hpUf)
  );

  irp_down_counter #(.W(8), .PW(8)) u_lp (
    .clock     (clock),
    .rst_b     (rst_b),
    .enable    (lpRun),
    .scaleSel  (pscal_reg[2:0]),
    .preset    (lppre_reg),
    .underflow (lpUf)
  );

  // ---------------- ir waveform ----------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      phase_reg <= IRP_HIGH;
    end else if (!irOn) begin
      phase_reg <= IRP_HIGH;
    end else if (lowOnly) begin
      if (lpUf) begin
        phase_reg <= (phase_reg == IRP_HIGH) ? IRP_LOW : IRP_HIGH;
      end
    end else begin
      case (phase_reg)
        IRP_HIGH: begin
          if (hpUf) begin
            phase_reg <= IRP_LOW;
          end
        end
        IRP_LOW: begin
          if (lpUf) begin
            phase_reg <= IRP_HIGH;
          end
        end
        default: begin
          phase_reg <= IRP_HIGH;
        end
      endcase
    end
  end

  // half a carrier period per underflow, hence the factor of two
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      carrier_reg <= 1'b0;
    end else if (!(irOn && irctl_reg[IRC_CARRIER_MODE])) begin
      carrier_reg <= 1'b0;
    end else if (c2Uf) begin
      carrier_reg <= ~carrier_reg;
    end
  end

  assign irWave = (phase_reg == IRP_HIGH) |
                  (irctl_reg[IRC_CARRIER_MODE] & carrier_reg);

  // ---------------- pins ----------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      p5Out      <= 4'h0;
      p5Oe       <= 4'h0;
      timerExtIn <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        p5Out[i] <= p5OutData[i];
        p5Oe[i]  <= ~p5dir_reg[P5_DIR_LSB + i];
      end
      if (irctl_reg[IRC_IR_PIN_SEL] && irOn) begin
        p5Out[PIN_IR] <= irWave;
        p5Oe[PIN_IR]  <= 1'b1;
      end
      timerExtIn <= irctl_reg[IRC_TIMER_IN_SEL] & p5In[PIN_TIMER];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      p6Out <= 8'h00;
      p6Oe  <= 8'h00;
    end else begin
      p6Out <= p6OutData;
      p6Oe  <= ~p6dir_reg;
    end
  end

  // a segment nibble overrides direction and drives the lcd level
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      p7Out <= 8'h00;
      p7Oe  <= 8'h00;
      p8Out <= 8'h00;
      p8Oe  <= 8'h00;
    end else begin
      p7Out[3:0] <= p5dir_reg[P5_P7L_SEG] ? lcdSeg[3:0] : p7OutData[3:0];
      p7Out[7:4] <= p5dir_reg[P5_P7H_SEG] ? lcdSeg[7:4] : p7OutData[7:4];
      p8Out[3:0] <= p5dir_reg[P5_P8L_SEG] ? lcdSeg[11:8] : p8OutData[3:0];
      p8Out[7:4] <= p5dir_reg[P5_P8H_SEG] ? lcdSeg[15:12] : p8OutData[7:4];
      p7Oe[3:0]  <= p5dir_reg[P5_P7L_SEG] ? 4'hf : ~p7dir_reg[3:0];
      p7Oe[7:4]  <= p5dir_reg[P5_P7H_SEG] ? 4'hf : ~p7dir_reg[7:4];
      p8Oe[3:0]  <= p5dir_reg[P5_P8L_SEG] ? 4'hf : ~p8dir_reg[3:0];
      p8Oe[7:4]  <= p5dir_reg[P5_P8H_SEG] ? 4'hf : ~p8dir_reg[7:4];
    end
  end

  // ---------------- interrupt flags ----------------
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      p5Prev_reg <= {p5In, 4'h0};
      p6Prev_reg <= p6In;
      p8Prev_reg <= p8In;
    end else begin
      p5Prev_reg <= {p5In, 4'h0};
      p6Prev_reg <= p6In;
      p8Prev_reg <= p8In;
    end
  end

  // only pins with direction bit 1 count; a port 8 segment nibble is driven yet still flags if those bits are 1
  assign portChange = |((p6In ^ p6Prev_reg) & p6dir_reg) |
                      |((p8In ^ p8Prev_reg) & p8dir_reg);
  // rising edge only; edge choice lives outside this bank
  assign irq0Edge = irctl_reg[IRC_EXT_IRQ0_SEL] & p5In[PIN_IRQ0] &
                    ~p5Prev_reg[P5_DIR_LSB + PIN_IRQ0];
  assign irq1Edge = irctl_reg[IRC_EXT_IRQ1_SEL] & p5In[PIN_IRQ1] &
                    ~p5Prev_reg[P5_DIR_LSB + PIN_IRQ1];

  always_comb begin
    setVec = 8'h00;
    setVec[FLG_PORT_CHANGE] = portChange;
    setVec[FLG_LOW_PULSE]   = lpUf;
    setVec[FLG_HIGH_PULSE]  = hpUf;
    setVec[FLG_COUNTER_TWO] = c2Uf;
    setVec[FLG_COUNTER_ONE] = c1Uf;
    setVec[FLG_EXT_IRQ1]    = irq1Edge;
    setVec[FLG_EXT_IRQ0]    = irq0Edge;
    setVec[FLG_TIMER_OVF]   = tcOverflow;
    clrVec = (wrEv && (wIdx_reg == IDX_FLAGS)) ? ~wb : 8'h00;
    flags_next = (irqFlags & ~clrVec) | setVec;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irqFlags <= RST_CTL;
    end else begin
      irqFlags <= flags_next;
    end
  end

endmodule

// >>> irp_pkg.sv
// shared constants for the ir, port function and timer control register bank
package irp_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_P5DIR = 8'h05;
  localparam logic [7:0] IDX_P6DIR = 8'h06;
  localparam logic [7:0] IDX_P7DIR = 8'h07;
  localparam logic [7:0] IDX_P8DIR = 8'h08;
  localparam logic [7:0] IDX_RAMIX = 8'h09;
  localparam logic [7:0] IDX_RAMDT = 8'h0a;
  localparam logic [7:0] IDX_C1PRE = 8'h0b;
  localparam logic [7:0] IDX_C2PRE = 8'h0c;
  localparam logic [7:0] IDX_IRCTL = 8'h0e;
  localparam logic [7:0] IDX_FLAGS = 8'h0f;
  localparam logic [7:0] IDX_CNTEN = 8'h10;
  localparam logic [7:0] IDX_CSCAL = 8'h11;
  localparam logic [7:0] IDX_PSCAL = 8'h12;
  localparam logic [7:0] IDX_HPPRE = 8'h13;
  localparam logic [7:0] IDX_LPPRE = 8'h14;

  // ir and pin function control fields
  localparam int IRC_INFRARED_ENABLE = 7;
  localparam int IRC_CARRIER_MODE    = 6;
  localparam int IRC_LOW_PULSE_ONLY  = 5;
  localparam int IRC_IR_PIN_SEL      = 3;
  localparam int IRC_TIMER_IN_SEL    = 2;
  localparam int IRC_EXT_IRQ1_SEL    = 1;
  localparam int IRC_EXT_IRQ0_SEL    = 0;
  localparam logic [7:0] IRC_WR_MASK = 8'hef;

  // interrupt flag positions
  localparam int FLG_PORT_CHANGE = 7;
  localparam int FLG_LOW_PULSE   = 6;
  localparam int FLG_HIGH_PULSE  = 5;
  localparam int FLG_COUNTER_TWO = 4;
  localparam int FLG_COUNTER_ONE = 3;
  localparam int FLG_EXT_IRQ1    = 2;
  localparam int FLG_EXT_IRQ0    = 1;
  localparam int FLG_TIMER_OVF   = 0;

  // port 5 control: direction in 7..4, segment selects in 3..0
  localparam int P5_DIR_LSB  = 4;
  localparam int P5_P8H_SEG  = 3;
  localparam int P5_P8L_SEG  = 2;
  localparam int P5_P7H_SEG  = 1;
  localparam int P5_P7L_SEG  = 0;

  // port 5 upper pins, numbered from pin 4
  localparam int PIN_IR      = 3;
  localparam int PIN_TIMER   = 2;
  localparam int PIN_IRQ1    = 1;
  localparam int PIN_IRQ0    = 0;

  // counter enable and prescale fields
  localparam int CEN_COUNTER_ONE = 0;
  localparam int CEN_COUNTER_TWO = 1;
  localparam int CEN_HIGH_PULSE  = 2;
  localparam int CEN_LOW_PULSE   = 3;
  localparam int CSC_ONE_LSB     = 0;
  localparam int CSC_TWO_LSB     = 4;

  localparam logic [7:0] RAM_INDEX_MASK = 8'h7f;
  localparam logic [7:0] RST_DIR        = 8'hff;
  localparam logic [7:0] RST_CTL        = 8'h00;

  typedef enum logic {
    IRP_LOW  = 1'b0,
    IRP_HIGH = 1'b1
  } irp_phase_e;

endpackage

// >>> irp_down_counter.sv
// auto-reload 8-bit down-counter behind a power-of-two prescaler
`timescale 1ns/100ps
module irp_down_counter #(
  parameter int W  = 8,
  parameter int PW = 8
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic         enable,
  input  wire logic [2:0]   scaleSel,
  input  wire logic [W-1:0] preset,
  output logic              underflow
);
  import irp_pkg::*;

  logic [PW-1:0] pre_reg;
  logic [W-1:0]  cnt_reg;
  logic [PW:0]   limWide;
  logic [PW-1:0] lim;
  logic          tick;

  // ratio is 2 << sel, so sel 7 gives 1:256
  // shift amount kept one bit wider so sel 7 does not wrap to a zero shift
  assign limWide = ({{PW{1'b0}}, 1'b1} << ({1'b0, scaleSel} + 4'h1)) - {{PW{1'b0}}, 1'b1};
  assign lim     = limWide[PW-1:0];
  assign tick    = (pre_reg == lim);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pre_reg   <= '0;
      cnt_reg   <= '0;
      underflow <= 1'b0;
    end else begin
      underflow <= 1'b0;
      if (!enable) begin
        // stopped counter restarts from the full preset
        pre_reg <= '0;
        cnt_reg <= preset;
      end else begin
        pre_reg <= tick ? '0 : pre_reg + 1'b1;
        if (tick) begin
          if (cnt_reg == '0) begin
            cnt_reg   <= preset;
            underflow <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
      end
    end
  end

endmodule

// >>> irp_aux_ram.sv
// flip-flop byte store reached through an index
`timescale 1ns/100ps
module irp_aux_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input  wire logic          clock,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] index,
  input  wire logic [DW-1:0] wrData,
  output logic      [DW-1:0] rdData
);
  import irp_pkg::*;

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // contents are not cleared by reset
  always_ff @(posedge clock) begin
    if (wrEn) begin
      mem[index] <= wrData;
    end
  end

  assign rdData = mem[index];

endmodule

// >>> irp_regs_sva.sv
// concurrent checks on the register bank's bus, pin and flag ports
`timescale 1ns/100ps
module irp_regs_chk (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [3:0]  p5In,
  input wire logic [7:0]  p6In,
  input wire logic [7:0]  p6Oe,
  input wire logic        tcOverflow,
  input wire logic        timerExtIn,
  input wire logic [7:0]  irqFlags
);
  import irp_pkg::*;
  logic wrPend_reg;
  // flags may only drop at the edge that ends a write to them
  always_ff @(posedge clock) begin
    wrPend_reg <= rst_b & hsel & htrans[1] & hready & hwrite & (haddr[9:2] == IDX_FLAGS);
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_rd;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  property p_rd_zero(logic c, logic [31:0] m);
    (s_rd ##0 c) |=> (hrdata & m) == 32'h0;
  endproperty
  a_ready_high: assert property (hreadyout) else $error("ready dropped");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_rdata_narrow: assert property (hrdata[31:8] == 24'h0) else $error("upper bits set");
  a_rdata_hold: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data moved");
  a_unmapped_zero: assert property (p_rd_zero(haddr[31:10] != 22'h0, 32'hffffffff))
    else $error("unmapped read not zero");
  a_index_msb_zero: assert property (p_rd_zero(haddr[9:2] == IDX_RAMIX, 32'h80))
    else $error("index bit 7 read as one");
  a_timer_flag_set: assert property (tcOverflow |=> irqFlags[0])
    else $error("overflow flag missed");
  a_flag_sticky: assert property (!wrPend_reg |=> (irqFlags & $past(irqFlags)) == $past(irqFlags))
    else $error("flag dropped without clear");
  a_port_change: assert property ((p6In != $past(p6In)) && p6Oe == 8'h00 && $stable(p6Oe)
    |-> ##[1:2] irqFlags[7])
    else $error("port change flag missed");
  a_timer_route: assert property (timerExtIn |-> $past(p5In[2]))
    else $error("timer input without pin");
endmodule

bind irp_regs irp_regs_chk u_chk (.*);

// >>> tb.sv
// self-checking bench for the ir, port function and timer register bank
`timescale 1ns/100ps
module tb;
  import irp_pkg::*;
  logic        clock, rst_b, hsel, hwrite, tcOverflow;
  logic [31:0] haddr, hwdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  p5In, p5OutData;
  logic [7:0]  p6In, p6OutData, p7In, p7OutData, p8In, p8OutData;
  logic [15:0] lcdSeg;
  wire         hready, hreadyout, hresp, timerExtIn;
  wire  [31:0] hrdata;
  wire  [3:0]  p5Out, p5Oe;
  wire  [7:0]  p6Out, p6Oe, p7Out, p7Oe, p8Out, p8Oe, irqFlags;
  int          errors, checks;

  assign hready = hreadyout;
  irp_regs uut (.*);

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("BAD t=%0t saw %h want %h", $time, s, e);
    end
  endtask

  // one idle cycle after each transfer keeps read-after-write safe
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= a;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, {22'h0, i, 2'b00}, {24'h0, d});
  endtask

  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    bus(1'b0, {22'h0, i, 2'b00}, 32'h0);
    chk(q, {24'h0, e});
  endtask

  task automatic wait_lvl(input int b, input logic v);
    int n;
    n = 0;
    @(negedge clock);
    while ((b < 8 ? irqFlags[b] : p5Out[3]) !== v && n < 600) begin
      @(negedge clock);
      n++;
    end
    if (n >= 600) errors++;
  endtask

  task automatic t_regs;
    logic [7:0] ix[6] = '{IDX_P5DIR, IDX_P6DIR, IDX_P7DIR, IDX_P8DIR, IDX_C1PRE, IDX_C2PRE};
    foreach (ix[i]) rc(ix[i], i < 4 ? 8'hff : 8'h00);
    rc(IDX_IRCTL, 8'h00);
    foreach (ix[i]) wr(ix[i], 8'h5a + 8'(i));
    foreach (ix[i]) rc(ix[i], 8'h5a + 8'(i));
    wr(IDX_RAMIX, 8'hff);
    rc(IDX_RAMIX, 8'h7f);
    wr(IDX_IRCTL, 8'hff);
    rc(IDX_IRCTL, 8'hef);
    wr(IDX_IRCTL, 8'h00);
    bus(1'b1, 32'h400, 32'hff);
    bus(1'b0, 32'h400, 32'h0);
    chk(q, 32'h0);
    rc(8'h0d, 8'h00);
  endtask

  task automatic t_ram;
    wr(IDX_RAMIX, 8'h05);
    wr(IDX_RAMDT, 8'ha5);
    wr(IDX_RAMIX, 8'h7f);
    wr(IDX_RAMDT, 8'h3c);
    wr(IDX_RAMIX, 8'h05);
    rc(IDX_RAMDT, 8'ha5);
    wr(IDX_RAMIX, 8'h7f);
    rc(IDX_RAMDT, 8'h3c);
  endtask

  task automatic t_pins;
    p6OutData <= 8'ha5;
    p7OutData <= 8'h3c;
    p8OutData <= 8'hc3;
    lcdSeg <= 16'h96e1;
    wr(IDX_P6DIR, 8'h0f);
    wr(IDX_P7DIR, 8'h0f);
    wr(IDX_P8DIR, 8'h0f);
    wr(IDX_P5DIR, 8'h30);
    repeat (2) @(negedge clock);
    chk({p5Oe, p6Oe, p6Out[7:4]}, 16'hcf0a);
    chk({p7Oe, p8Oe}, 16'hf0f0);
    chk({p8Out, p7Out}, 16'hc33c);
    wr(IDX_P5DIR, 8'h3f);
    repeat (2) @(negedge clock);
    chk({p7Oe, p8Oe}, 16'hffff);
    chk({p8Out, p7Out}, 16'h96e1);
    wr(IDX_P6DIR, 8'hff);
  endtask

  task automatic t_flags;
    wr(IDX_P5DIR, 8'h70);
    wr(IDX_IRCTL, 8'h07);
    wr(IDX_FLAGS, 8'h00);
    p5In <= 4'h7;
    p6In <= 8'h5a;
    tcOverflow <= 1'b1;
    @(posedge clock);
    tcOverflow <= 1'b0;
    @(negedge clock);
    chk(timerExtIn, 1'b1);
    rc(IDX_FLAGS, 8'h87);
    wr(IDX_FLAGS, 8'h7f);
    rc(IDX_FLAGS, 8'h07);
    // overflow pulse lands on the same edge as the clearing write
    fork
      wr(IDX_FLAGS, 8'h00);
      begin
        repeat (2) @(posedge clock);
        tcOverflow <= 1'b1;
        @(posedge clock);
        tcOverflow <= 1'b0;
      end
    join
    rc(IDX_FLAGS, 8'h01);
    p5In <= 4'h0;
  endtask

  task automatic t_counter(input int b, input logic [7:0] en, input logic [7:0] pre);
    realtime t0;
    wr(pre, 8'h09);
    wr(IDX_CSCAL, 8'h11);
    wr(IDX_FLAGS, 8'h00);
    wr(IDX_CNTEN, en);
    wait_lvl(b, 1'b1);
    t0 = $realtime;
    wr(IDX_FLAGS, 8'h00);
    wait_lvl(b, 1'b1);
    chk(32'(int'(($realtime - t0) / 100.0)), 32'((9 + 1) * (2 << 1)));
    wr(IDX_CNTEN, 8'h00);
    wr(IDX_FLAGS, 8'h00);
    repeat (60) @(posedge clock);
    rc(IDX_FLAGS, 8'h00);
    rc(pre, 8'h09);
  endtask

  task automatic t_ir;
    realtime t0;
    p5OutData <= 4'h8;
    wr(IDX_P5DIR, 8'h70);
    wr(IDX_IRCTL, 8'h08);
    @(negedge clock);
    chk({p5Oe[3], p5Out[3]}, 2'b11);
    wr(IDX_PSCAL, 8'h00);
    wr(IDX_LPPRE, 8'h04);
    wr(IDX_CNTEN, 8'h08);
    wr(IDX_IRCTL, 8'ha8);
    wait_lvl(8, 1'b0);
    wait_lvl(8, 1'b1);
    t0 = $realtime;
    wait_lvl(8, 1'b0);
    chk(32'(int'(($realtime - t0) / 100.0)), 32'((4 + 1) * 2));
    chk(irqFlags[6], 1'b1);
    // carrier mode: short high phase, long low phase carrying the carrier
    wr(IDX_IRCTL, 8'h08);
    wr(IDX_C2PRE, 8'h04);
    wr(IDX_CSCAL, 8'h00);
    wr(IDX_HPPRE, 8'h00);
    wr(IDX_LPPRE, 8'hff);
    wr(IDX_PSCAL, 8'h03);
    wr(IDX_CNTEN, 8'h0e);
    wr(IDX_IRCTL, 8'hc8);
    wait_lvl(8, 1'b0);
    wait_lvl(8, 1'b1);
    t0 = $realtime;
    wait_lvl(8, 1'b0);
    chk(32'(int'(($realtime - t0) / 100.0)), 32'((4 + 1) * 2));
    chk(irqFlags[5], 1'b1);
  endtask

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    repeat (8000) @(posedge clock);
    errors++;
    tally_and_finish;
  end

  initial begin
    {rst_b, hsel, hwrite, tcOverflow, haddr, hwdata, htrans} = '0;
    {p5In, p5OutData, p6In, p6OutData, p7In, p7OutData, p8In, p8OutData, lcdSeg} = '0;
    hsize = 3'b010;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    t_regs;
    t_ram;
    t_pins;
    t_flags;
    t_counter(FLG_COUNTER_ONE, 8'h01, IDX_C1PRE);
    t_counter(FLG_COUNTER_TWO, 8'h02, IDX_C2PRE);
    t_ir;
    tally_and_finish;
  end
endmodule
